// *** design/scp_pair_buffer.sv ***
`timescale 1ns/1ps
`include "scp_regs.svh"

module scp_pair_buffer #(
  parameter int WIDTH = `SCP_BYTE_BITS,
  parameter int DEPTH = `SCP_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + (AW+1)'(1);
    end else if (pop && !push) begin
      count_q <= count_q - (AW+1)'(1);
    end
  end

endmodule

// *** design/scp_pin_mux.sv ***
`timescale 1ns/1ps
`include "scp_regs.svh"

module scp_pin_mux
  import scp_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  // Mode control, bit 0 unit one, bit 1 unit two
  input  wire scp_mode_type unit_one_mode_i,
  input  wire scp_mode_type unit_two_mode_i,
  input  wire logic [1:0]   sync_master_i,
  output logic              unit_one_async_o,
  output logic              unit_two_mode_bad_o,
  // Serial core outputs
  input  wire logic [1:0]   sync_dout_i,
  input  wire logic [1:0]   sync_sck_i,
  input  wire logic [1:0]   tw_sda_low_i,
  input  wire logic [1:0]   tw_scl_low_i,
  // Serial core inputs
  output logic      [1:0]   sync_din_o,
  output logic      [1:0]   sync_sck_o,
  output logic      [1:0]   sync_sel_n_o,
  output logic      [1:0]   tw_sda_o,
  output logic      [1:0]   tw_scl_o,
  // Polled receive path
  output scp_byte_type      unit_one_rx_data_o,
  output scp_byte_type      unit_two_rx_data_o,
  output logic      [1:0]   rx_valid_o,
  input  wire logic [1:0]   rx_ready_i,
  output logic      [1:0]   rx_overrun_o,
  // Ordinary port control
  input  wire logic [3:0]   gpio_pa_out_i,
  input  wire logic [3:0]   gpio_pa_oe_i,
  input  wire logic [3:0]   gpio_pb_out_i,
  input  wire logic [3:0]   gpio_pb_oe_i,
  // Port A pins 0..3 and port B pins 1..4
  input  wire logic [3:0]   pa_in_i,
  output logic      [3:0]   pa_out_o,
  output logic      [3:0]   pa_oe_o,
  input  wire logic [3:0]   pb_in_i,
  output logic      [3:0]   pb_out_o,
  output logic      [3:0]   pb_oe_o
);

  scp_mode_type     mode_eff [2];
  logic [3:0]       pa_meta_q;
  logic [3:0]       pa_s_q;
  logic [3:0]       pb_meta_q;
  logic [3:0]       pb_s_q;
  logic [1:0]       sck_pin;
  logic [1:0]       push;
  logic [1:0]       push_ready;
  scp_byte_type     push_byte [2];
  scp_byte_type     rx_byte [2];

  // Unit two has no asynchronous engine, so that code is folded onto disabled
  always_comb begin
    mode_eff[0] = unit_one_mode_i;
    mode_eff[1] = (unit_two_mode_i == `SCP_MODE_ASYNC) ? `SCP_MODE_OFF : unit_two_mode_i;
  end

  assign unit_one_async_o    = (unit_one_mode_i == `SCP_MODE_ASYNC);
  assign unit_two_mode_bad_o = (unit_two_mode_i == `SCP_MODE_ASYNC);

  // Pins are asynchronous to ref_clk_i; the first stage feeds only the second
  // Reset to the pulled-up idle level, so no false select or clock edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pa_meta_q <= 4'hf;
      pb_meta_q <= 4'hf;
    end else begin
      pa_meta_q <= pa_in_i;
      pb_meta_q <= pb_in_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pa_s_q <= 4'hf;
      pb_s_q <= 4'hf;
    end else begin
      pa_s_q <= pa_meta_q;
      pb_s_q <= pb_meta_q;
    end
  end

  // Port B, unit one
  always_comb begin
    pb_out_o        = gpio_pb_out_i;
    pb_oe_o         = gpio_pb_oe_i;
    sync_din_o[0]   = 1'b0;
    sck_pin[0]      = 1'b0;
    sync_sel_n_o[0] = 1'b1;
    tw_sda_o[0]     = 1'b1;
    tw_scl_o[0]     = 1'b1;
    case (mode_eff[0])
      `SCP_MODE_SYNC: begin
        pb_out_o[`SCP_PB1] = sync_dout_i[0];
        pb_oe_o[`SCP_PB1]  = 1'b1;
        sync_din_o[0]      = pb_s_q[`SCP_PB2];
        if (sync_master_i[0]) begin
          pb_out_o[`SCP_PB3] = sync_sck_i[0];
          pb_oe_o[`SCP_PB3]  = 1'b1;
        end else begin
          sck_pin[0]      = pb_s_q[`SCP_PB3];
          sync_sel_n_o[0] = pb_s_q[`SCP_PB4];
        end
      end
      `SCP_MODE_TWO: begin
        pb_out_o[`SCP_PB1] = 1'b0;
        pb_oe_o[`SCP_PB1]  = tw_sda_low_i[0];
        pb_out_o[`SCP_PB2] = 1'b0;
        pb_oe_o[`SCP_PB2]  = tw_scl_low_i[0];
        tw_sda_o[0]        = pb_s_q[`SCP_PB1];
        tw_scl_o[0]        = pb_s_q[`SCP_PB2];
      end
      default: begin
      end
    endcase
  end

  // Port A, unit two
  always_comb begin
    pa_out_o        = gpio_pa_out_i;
    pa_oe_o         = gpio_pa_oe_i;
    sync_din_o[1]   = 1'b0;
    sck_pin[1]      = 1'b0;
    sync_sel_n_o[1] = 1'b1;
    tw_sda_o[1]     = 1'b1;
    tw_scl_o[1]     = 1'b1;
    case (mode_eff[1])
      `SCP_MODE_SYNC: begin
        if (sync_master_i[1]) begin
          pa_out_o[`SCP_PA0] = sync_dout_i[1];
          pa_oe_o[`SCP_PA0]  = 1'b1;
          sync_din_o[1]      = pa_s_q[`SCP_PA1];
          pa_out_o[`SCP_PA2] = sync_sck_i[1];
          pa_oe_o[`SCP_PA2]  = 1'b1;
        end else begin
          sync_din_o[1]      = pa_s_q[`SCP_PA0];
          pa_out_o[`SCP_PA1] = sync_dout_i[1];
          pa_oe_o[`SCP_PA1]  = 1'b1;
          sck_pin[1]         = pa_s_q[`SCP_PA2];
          sync_sel_n_o[1]    = pa_s_q[`SCP_PA3];
        end
      end
      `SCP_MODE_TWO: begin
        pa_out_o[`SCP_PA1] = 1'b0;
        pa_oe_o[`SCP_PA1]  = tw_sda_low_i[1];
        pa_out_o[`SCP_PA2] = 1'b0;
        pa_oe_o[`SCP_PA2]  = tw_scl_low_i[1];
        tw_sda_o[1]        = pa_s_q[`SCP_PA1];
        tw_scl_o[1]        = pa_s_q[`SCP_PA2];
      end
      default: begin
      end
    endcase
  end

  assign sync_sck_o = sck_pin;

  // Byte receiver and two-entry buffer per unit
  for (genvar u = 0; u < 2; u++) begin : g_unit
    scp_rx_state_type state_q;
    logic             clk_lvl;
    logic             clk_prev_q;
    logic             active;
    logic [2:0]       bit_q;
    scp_byte_type     shift_q;
    logic             push_q;
    scp_byte_type     byte_q;

    // A master samples its own clock; a slave samples the pin and its select
    assign clk_lvl = sync_master_i[u] ? sync_sck_i[u] : sck_pin[u];
    assign active  = (mode_eff[u] == `SCP_MODE_SYNC) &&
                     (sync_master_i[u] || !sync_sel_n_o[u]);

    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        clk_prev_q <= 1'b1;
      end else begin
        clk_prev_q <= clk_lvl;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        state_q <= SCP_RX_IDLE;
      end else begin
        case (state_q)
          SCP_RX_IDLE:  state_q <= active ? SCP_RX_SHIFT : SCP_RX_IDLE;
          SCP_RX_SHIFT: state_q <= active ? SCP_RX_SHIFT : SCP_RX_IDLE;
          default:      state_q <= SCP_RX_IDLE;
        endcase
      end
    end

    // A deselect mid-byte drops the partial byte rather than misaligning the next
    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        bit_q   <= 3'h0;
        shift_q <= 8'h00;
      end else if (state_q != SCP_RX_SHIFT || !active) begin
        bit_q <= 3'h0;
      end else if (clk_lvl && !clk_prev_q) begin
        bit_q   <= bit_q + 3'h1;
        shift_q <= {shift_q[6:0], sync_din_o[u]};
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        push_q <= 1'b0;
        byte_q <= 8'h00;
      end else begin
        push_q <= (state_q == SCP_RX_SHIFT) && active && clk_lvl && !clk_prev_q &&
                  (bit_q == `SCP_LAST_BIT);
        byte_q <= {shift_q[6:0], sync_din_o[u]};
      end
    end

    assign push[u]      = push_q;
    assign push_byte[u] = byte_q;

    // The link cannot be stalled, so a full buffer costs the new byte
    assign rx_overrun_o[u] = push_q && !push_ready[u];

    scp_pair_buffer #(
      .WIDTH (`SCP_BYTE_BITS),
      .DEPTH (`SCP_BUF_DEPTH)
    ) u_buf (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (push[u]),
      .in_ready_o  (push_ready[u]),
      .in_data_i   (push_byte[u]),
      .out_valid_o (rx_valid_o[u]),
      .out_ready_i (rx_ready_i[u]),
      .out_data_o  (rx_byte[u])
    );
  end

  assign unit_one_rx_data_o = rx_byte[0];
  assign unit_two_rx_data_o = rx_byte[1];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_u1_slave_steady;
    (unit_one_mode_i == `SCP_MODE_SYNC && !sync_master_i[0])[*3];
  endsequence

  sequence s_u1_tw_steady;
    (unit_one_mode_i == `SCP_MODE_TWO)[*4];
  endsequence

  chk_u1_master_pins: assert property (
    (mode_eff[0] == `SCP_MODE_SYNC && sync_master_i[0]) |->
      (pb_oe_o[0] && pb_oe_o[2] && pb_out_o[0] == sync_dout_i[0] &&
       pb_out_o[2] == sync_sck_i[0] && pb_oe_o[3] == gpio_pb_oe_i[3]))
    else $error("unit one master pin map wrong");

  chk_u1_slave_sync: assert property (
    s_u1_slave_steady |-> (sync_din_o[0] == $past(pb_in_i[1], 2) &&
                           sync_sel_n_o[0] == $past(pb_in_i[3], 2) && pb_oe_o[0]))
    else $error("unit one slave input path wrong");

  chk_u1_tw_drain: assert property (
    (mode_eff[0] == `SCP_MODE_TWO) |->
      (pb_out_o[1:0] == 2'h0 && pb_oe_o[0] == tw_sda_low_i[0] &&
       pb_oe_o[1] == tw_scl_low_i[0] && pb_oe_o[3:2] == gpio_pb_oe_i[3:2]))
    else $error("unit one two-wire pins wrong");

  chk_u2_master_pins: assert property (
    (mode_eff[1] == `SCP_MODE_SYNC && sync_master_i[1]) |->
      (pa_oe_o[0] && pa_oe_o[2] && pa_out_o[2] == sync_sck_i[1] &&
       sync_din_o[1] == pa_s_q[1] && pa_oe_o[3] == gpio_pa_oe_i[3]))
    else $error("unit two master pin map wrong");

  chk_u2_slave_pins: assert property (
    (mode_eff[1] == `SCP_MODE_SYNC && !sync_master_i[1]) |->
      (pa_oe_o[1] && pa_out_o[1] == sync_dout_i[1] && pa_oe_o[0] == gpio_pa_oe_i[0] &&
       sync_sck_o[1] == pa_s_q[2]))
    else $error("unit two slave pin map wrong");

  chk_u2_tw_drain: assert property (
    (mode_eff[1] == `SCP_MODE_TWO) |->
      (pa_oe_o[1] == tw_sda_low_i[1] && pa_oe_o[2] == tw_scl_low_i[1] &&
       pa_out_o[2:1] == 2'h0 && pa_oe_o[0] == gpio_pa_oe_i[0]))
    else $error("unit two two-wire pins wrong");

  chk_off_released: assert property (
    (unit_one_mode_i == `SCP_MODE_OFF) |->
      (pb_out_o == gpio_pb_out_i && pb_oe_o == gpio_pb_oe_i))
    else $error("disabled unit drives its pins");

  chk_u2_no_async: assert property (
    (unit_two_mode_i == `SCP_MODE_ASYNC) |->
      (pa_oe_o == gpio_pa_oe_i && pa_out_o == gpio_pa_out_i && unit_two_mode_bad_o &&
       (!push[1] || $past(mode_eff[1]) == `SCP_MODE_SYNC)))
    else $error("unit two acts on asynchronous code");

  chk_tw_no_fill: assert property (
    s_u1_tw_steady |-> !push[0] ##1 !push[0])
    else $error("two-wire mode fills the buffer");

  chk_rx_poll_hold: assert property (
    (rx_valid_o[0] && !rx_ready_i[0]) |=> (rx_valid_o[0] &&
      $stable(unit_one_rx_data_o)))
    else $error("polled byte lost before read");

endmodule

// *** inc/scp_pkg.sv ***
package scp_pkg;

  typedef logic [1:0] scp_mode_type;
  typedef logic [7:0] scp_byte_type;

  typedef enum logic {
    SCP_RX_IDLE,
    SCP_RX_SHIFT
  } scp_rx_state_type;

endpackage

// *** inc/scp_regs.svh ***
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Operating mode field codes
`define SCP_MODE_OFF    2'h0
`define SCP_MODE_ASYNC  2'h1
`define SCP_MODE_SYNC   2'h2
`define SCP_MODE_TWO    2'h3

// Port A pin positions, unit two
`define SCP_PA0         0
`define SCP_PA1         1
`define SCP_PA2         2
`define SCP_PA3         3

// Port B pin positions, unit one (bit 0 is pin 1)
`define SCP_PB1         0
`define SCP_PB2         1
`define SCP_PB3         2
`define SCP_PB4         3

// Receive path
`define SCP_BYTE_BITS   8
`define SCP_LAST_BIT    3'h7
`define SCP_BUF_DEPTH   2

`endif

// *** tb/scp_periph_model.sv ***
`timescale 1ns/1ps

module scp_periph_model (
  // Pad side of the device
  input  wire logic [3:0] pa_out_i,
  input  wire logic [3:0] pa_oe_i,
  input  wire logic [3:0] pb_out_i,
  input  wire logic [3:0] pb_oe_i,
  // Levels seen at the pins
  output logic      [3:0] pa_pin_o,
  output logic      [3:0] pb_pin_o
);
  // Far-side drive; idle lines sit high as if pulled up
  logic [3:0] drv_a = 4'hf;
  logic [3:0] drv_b = 4'hf;

  // A driving device wins over the far side
  assign pa_pin_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & drv_a);
  assign pb_pin_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & drv_b);

  task automatic put(input int u, input int idx, input logic v);
    if (u == 0) begin
      drv_b[idx] = v;
    end else begin
      drv_a[idx] = v;
    end
  endtask

  // External master clocking one byte into a slave unit
  task automatic send_byte(input int u, input logic [7:0] b);
    int d;
    d = (u == 0) ? 1 : 0;
    put(u, 2, 1'b0);
    put(u, 3, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      put(u, d, b[i]);
      #400 put(u, 2, 1'b1);
      #400 put(u, 2, 1'b0);
    end
    #400 put(u, 3, 1'b1);
    // Released line must not keep showing the last bit
    put(u, d, ~b[0]);
    // Keep the select high for a while so back-to-back bytes see a real deselect
    #400;
  endtask
endmodule

// *** tb/scp_pin_mux_bench.sv ***
`timescale 1ns/1ps

module scp_pin_mux_bench
  import scp_pkg::*;
;
  logic         ref_clk_i       = 1'b0;
  logic         resetn_i        = 1'b0;
  scp_mode_type unit_one_mode_i = 2'h0;
  scp_mode_type unit_two_mode_i = 2'h0;
  logic [1:0]   sync_master_i   = 2'h0;
  logic [1:0]   sync_dout_i     = 2'h0;
  logic [1:0]   sync_sck_i      = 2'h0;
  logic [1:0]   tw_sda_low_i    = 2'h0;
  logic [1:0]   tw_scl_low_i    = 2'h0;
  logic [1:0]   rx_ready_i      = 2'h0;
  logic [3:0]   gpio_pa_out_i   = 4'h0;
  logic [3:0]   gpio_pa_oe_i    = 4'h0;
  logic [3:0]   gpio_pb_out_i   = 4'h0;
  logic [3:0]   gpio_pb_oe_i    = 4'h0;
  logic [3:0]   pa_in_i, pb_in_i, pa_out_o, pa_oe_o, pb_out_o, pb_oe_o;
  logic [1:0]   sync_din_o, sync_sck_o, sync_sel_n_o, tw_sda_o, tw_scl_o;
  logic [1:0]   rx_valid_o, rx_overrun_o;
  logic         unit_one_async_o, unit_two_mode_bad_o, rdy_rand;
  scp_byte_type unit_one_rx_data_o, unit_two_rx_data_o, b;
  scp_byte_type exp_q [2][$];
  int           ovr_seen [2];
  int           errors = 0;
  int           checks_done = 0;

  scp_pin_mux uut (
    .ref_clk_i, .resetn_i, .unit_one_mode_i, .unit_two_mode_i, .sync_master_i,
    .unit_one_async_o, .unit_two_mode_bad_o, .sync_dout_i, .sync_sck_i,
    .tw_sda_low_i, .tw_scl_low_i, .sync_din_o, .sync_sck_o, .sync_sel_n_o,
    .tw_sda_o, .tw_scl_o, .unit_one_rx_data_o,
    .unit_two_rx_data_o, .rx_valid_o, .rx_ready_i, .rx_overrun_o, .gpio_pa_out_i,
    .gpio_pa_oe_i, .gpio_pb_out_i, .gpio_pb_oe_i, .pa_in_i, .pa_out_o, .pa_oe_o,
    .pb_in_i, .pb_out_o, .pb_oe_o
  );

  scp_periph_model model (
    .pa_out_i(pa_out_o), .pa_oe_i(pa_oe_o), .pb_out_i(pb_out_o), .pb_oe_i(pb_oe_o),
    .pa_pin_o(pa_in_i), .pb_pin_o(pb_in_i)
  );

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected pad drive of one unit from its mode, role and core requests
  task automatic pin_check(input int u, input logic [3:0] oe_s, out_s, g_oe, g_out);
    logic [1:0] md;
    logic [3:0] cm, coe, cv;
    md = (u == 1) ? unit_two_mode_i : unit_one_mode_i;
    cv = {1'b0, sync_sck_i[u], (u == 1) ? sync_dout_i[u] : 1'b0, sync_dout_i[u]};
    if (md == 2'h2) begin
      cm = sync_master_i[u] ? 4'h5 : ((u == 1) ? 4'h2 : 4'h1);
      coe = cm;
    end else if (md == 2'h3) begin
      cm = (u == 1) ? 4'h6 : 4'h3;
      coe = {2'h0, tw_scl_low_i[u], tw_sda_low_i[u]} << u;
      cv = 4'h0;
    end else begin
      cm = 4'hf;
      coe = g_oe;
      cv = g_out;
    end
    check(8'(oe_s & cm), 8'(coe));
    check(8'(out_s & coe), 8'(cv & coe));
  endtask

  // Pin levels that the cores must see once the pins have stood two edges
  task automatic in_check(input int u, input logic [1:0] md, input logic [3:0] pin);
    int   di;
    int   ci;
    logic sl;
    di = (u == 1) ? int'(sync_master_i[u]) : 1;
    ci = (u == 1) ? 2 : 1;
    sl = (md == 2'h2) && !sync_master_i[u];
    check(8'(tw_scl_o[u]), 8'((md != 2'h3) || pin[ci]));
    check(8'(sync_din_o[u]), 8'((md == 2'h2) && pin[di]));
    check(8'(sync_sck_o[u]), 8'(sl && pin[2]));
    check(8'(sync_sel_n_o[u]), 8'(!sl || pin[3]));
  endtask

  // Received bytes are compared against the oldest note
  always @(posedge ref_clk_i) begin
    for (int u = 0; u < 2; u++) begin
      scp_byte_type got, want;
      got = (u == 1) ? unit_two_rx_data_o : unit_one_rx_data_o;
      if (resetn_i && rx_overrun_o[u] === 1'b1) begin
        ovr_seen[u]++;
      end
      if (resetn_i && rx_valid_o[u] === 1'b1 && rx_ready_i[u] === 1'b1) begin
        want = (exp_q[u].size() > 0) ? exp_q[u].pop_front() : ~got;
        check(got, want);
      end
    end
  end

  always @(negedge ref_clk_i) begin
    if (rdy_rand) begin
      rx_ready_i <= 2'($urandom);
    end
  end

  initial begin
    #500000;
    errors++;
    final_report();
  end

  initial begin
    rdy_rand = 1'b0;
    void'($urandom(13752));
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge ref_clk_i);
      {unit_one_mode_i, unit_two_mode_i, sync_master_i, sync_dout_i} = 8'($urandom);
      {sync_sck_i, tw_sda_low_i, tw_scl_low_i} = 6'($urandom);
      {gpio_pa_out_i, gpio_pa_oe_i, gpio_pb_out_i, gpio_pb_oe_i} = 16'($urandom);
      #20;
      pin_check(0, pb_oe_o, pb_out_o, gpio_pb_oe_i, gpio_pb_out_i);
      pin_check(1, pa_oe_o, pa_out_o, gpio_pa_oe_i, gpio_pa_out_i);
      check(8'(unit_one_async_o), 8'(unit_one_mode_i == 2'h1));
      check(8'(unit_two_mode_bad_o), 8'(unit_two_mode_i == 2'h1));
      repeat (3) @(posedge ref_clk_i);
      #10;
      check(8'(tw_sda_o[0]), 8'((unit_one_mode_i != 2'h3) || !tw_sda_low_i[0]));
      check(8'(tw_sda_o[1]), 8'((unit_two_mode_i != 2'h3) || !tw_sda_low_i[1]));
      in_check(0, unit_one_mode_i, pb_in_i);
      in_check(1, unit_two_mode_i, pa_in_i);
    end
    // Mid-run reset flushes whatever the random pins clocked into the buffers
    @(negedge ref_clk_i);
    resetn_i = 1'b0;
    {gpio_pa_oe_i, gpio_pb_oe_i} = 8'h00;
    {tw_sda_low_i, tw_scl_low_i, rx_ready_i, sync_master_i} = 8'h00;
    sync_sck_i = 2'h0;
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    check(8'(rx_valid_o), 8'h00);
    // Stalled receiver: two bytes kept, third dropped with an overrun
    unit_one_mode_i = 2'h2;
    unit_two_mode_i = 2'h2;
    ovr_seen[0] = 0;
    ovr_seen[1] = 0;
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      if (k < 2) begin
        exp_q[0].push_back(b);
      end
      model.send_byte(0, b);
    end
    repeat (10) @(posedge ref_clk_i);
    check(8'(ovr_seen[0]), 8'h01);
    @(negedge ref_clk_i);
    rx_ready_i = 2'h1;
    repeat (4) @(negedge ref_clk_i);
    check(8'(rx_valid_o), 8'h00);
    // Both units at once with a randomly stalling reader
    rdy_rand = 1'b1;
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      exp_q[0].push_back(b);
      exp_q[1].push_back(~b);
      fork
        model.send_byte(0, b);
        model.send_byte(1, ~b);
      join
    end
    repeat (20) @(negedge ref_clk_i);
    rdy_rand = 1'b0;
    @(negedge ref_clk_i);
    rx_ready_i = 2'h0;
    check(8'(exp_q[0].size() + exp_q[1].size()), 8'h00);
    check(8'(ovr_seen[0] + ovr_seen[1]), 8'h01);
    // Master role: the core's own clock takes the data pin in on both units
    @(negedge ref_clk_i);
    b = 8'($urandom);
    exp_q[0].push_back(b);
    exp_q[1].push_back(b);
    rx_ready_i = 2'h3;
    sync_master_i = 2'h3;
    for (int i = 7; i >= 0; i--) begin
      model.put(0, 1, b[i]);
      model.put(1, 1, b[i]);
      repeat (4) @(negedge ref_clk_i);
      sync_sck_i = 2'h3;
      repeat (4) @(negedge ref_clk_i);
      sync_sck_i = 2'h0;
    end
    repeat (6) @(negedge ref_clk_i);
    check(8'(exp_q[0].size() + exp_q[1].size()), 8'h00);
    // Two-wire and disabled units must not receive, whatever the role input says
    unit_one_mode_i = 2'h3;
    unit_two_mode_i = 2'h0;
    fork
      model.send_byte(0, 8'h5a);
      model.send_byte(1, 8'ha5);
    join
    repeat (10) @(negedge ref_clk_i);
    check(8'(rx_valid_o), 8'h00);
    final_report();
  end
endmodule
